// ---- host_port_defs.svh ----
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// serial pin positions on the shared data bus
`define SER_DATA_BIT 7
`define SER_CLK_BIT 6
// serial byte length and counter reset value
`define SER_BITS 4'h8
`define SER_CNT_RST 4'h0
// reset values
`define BYTE_RST 8'h00
`define SYNC_RST 2'h0

`endif

// ---- host_port_pkg.sv ----
package host_port_pkg;
    // bus cycle phases of the parallel port
    typedef enum logic [1:0] {
        IDLE,
        WRITE_CYCLE,
        READ_CYCLE
    } phase_type;
endpackage

// ---- lcd_driver_host_interface.sv ----
// Function
// - eight bit two-way parallel data bus
// - serial data on D7, clock on D6
// - flag low command, high display data
// - init held while init request low
// - transfers only when both selects active
// - deselected bus lines stay undriven
// - 8080 read strobe low drives bus
// - 6800 enable high frames bus cycle
// - 8080 store strobe low writes
// - 6800 rw high read, low write
// - style select high 6800, low 8080
// - parallel select high parallel, low serial
// - serial mode is write only
// - serial mode leaves D0 to D5 undriven
`timescale 1ns/10ps
`include "host_port_defs.svh"

module lcd_driver_host_interface (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic INIT_REQUEST_N,
    input wire logic SELECT_LOW_N,
    input wire logic SELECT_HIGH,
    input wire logic CMD_DATA_FLAG,
    input wire logic BUS_STYLE_SELECT,
    input wire logic PARALLEL_SERIAL_SELECT,
    input wire logic READ_STROBE_N,
    input wire logic STORE_STROBE_N,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic [7:0] DATA_OE_N,
    input wire logic [7:0] READ_DATA,
    output logic READ_REQ,
    output logic [7:0] WRITE_DATA,
    output logic WRITE_IS_DISPLAY,
    output logic WRITE_VALID,
    output logic INIT_ACTIVE
);

    // two-stage synchronisers for every pin input
    logic [1:0] init_sync_reg, init_sync_next;
    logic [1:0] csl_sync_reg, csl_sync_next;
    logic [1:0] csh_sync_reg, csh_sync_next;
    logic [1:0] flag_sync_reg, flag_sync_next;
    logic [1:0] style_sync_reg, style_sync_next;
    logic [1:0] ps_sync_reg, ps_sync_next;
    logic [1:0] rd_sync_reg, rd_sync_next;
    logic [1:0] wr_sync_reg, wr_sync_next;
    logic [7:0] d_meta_reg, d_meta_next;
    logic [7:0] d_sync_reg, d_sync_next;

    always_comb begin
        init_sync_next = {init_sync_reg[0], INIT_REQUEST_N};
        csl_sync_next = {csl_sync_reg[0], SELECT_LOW_N};
        csh_sync_next = {csh_sync_reg[0], SELECT_HIGH};
        flag_sync_next = {flag_sync_reg[0], CMD_DATA_FLAG};
        style_sync_next = {style_sync_reg[0], BUS_STYLE_SELECT};
        ps_sync_next = {ps_sync_reg[0], PARALLEL_SERIAL_SELECT};
        rd_sync_next = {rd_sync_reg[0], READ_STROBE_N};
        wr_sync_next = {wr_sync_reg[0], STORE_STROBE_N};
        d_meta_next = DATA_IN;
        d_sync_next = d_meta_reg;
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            init_sync_reg <= `SYNC_RST;
            csl_sync_reg <= 2'h3;
            csh_sync_reg <= `SYNC_RST;
            flag_sync_reg <= `SYNC_RST;
            style_sync_reg <= `SYNC_RST;
            ps_sync_reg <= 2'h3;
            rd_sync_reg <= 2'h3;
            wr_sync_reg <= 2'h3;
            d_meta_reg <= `BYTE_RST;
            d_sync_reg <= `BYTE_RST;
        end else begin
            init_sync_reg <= init_sync_next;
            csl_sync_reg <= csl_sync_next;
            csh_sync_reg <= csh_sync_next;
            flag_sync_reg <= flag_sync_next;
            style_sync_reg <= style_sync_next;
            ps_sync_reg <= ps_sync_next;
            rd_sync_reg <= rd_sync_next;
            wr_sync_reg <= wr_sync_next;
            d_meta_reg <= d_meta_next;
            d_sync_reg <= d_sync_next;
        end
    end

    // decoded conditions from synchronised levels
    logic init_now, selected, style_6800, parallel, rw_read;
    logic rd_pin, wr_pin, access, acc_read, acc_write;
    assign init_now = ~init_sync_reg[1];
    assign selected = ~csl_sync_reg[1] & csh_sync_reg[1] & ~init_now;
    assign style_6800 = style_sync_reg[1];
    assign parallel = ps_sync_reg[1];
    assign rd_pin = rd_sync_reg[1];
    assign wr_pin = wr_sync_reg[1];
    assign rw_read = wr_pin;
    // parallel cycle framing per bus style
    always_comb begin
        if (style_6800) begin
            access = rd_pin;
            acc_read = access & rw_read;
            acc_write = access & ~rw_read;
        end else begin
            access = ~rd_pin | ~wr_pin;
            acc_read = ~rd_pin;
            acc_write = ~wr_pin & rd_pin;
        end
    end

    // parallel bus phase and output drive
    host_port_pkg::phase_type phase_reg, phase_next;
    logic [7:0] out_reg, out_next;
    logic [7:0] oe_n_reg, oe_n_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wflag_reg, wflag_next;
    logic wvalid_reg, wvalid_next;
    logic rreq_reg, rreq_next;
    logic init_reg, init_next;

    // serial shifter state
    logic [7:0] shift_reg, shift_next;
    logic [3:0] cnt_reg, cnt_next;
    logic sclk_prev_reg, sclk_prev_next;
    logic sclk_rise;
    assign sclk_rise = d_sync_reg[`SER_CLK_BIT] & ~sclk_prev_reg;

    always_comb begin
        phase_next = phase_reg;
        out_next = out_reg;
        oe_n_next = 8'hff;
        wdata_next = wdata_reg;
        wflag_next = wflag_reg;
        wvalid_next = 1'b0;
        rreq_next = 1'b0;
        init_next = init_now;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        sclk_prev_next = d_sync_reg[`SER_CLK_BIT];
        if (init_now || !selected) begin
            phase_next = host_port_pkg::IDLE;
            cnt_next = `SER_CNT_RST;
        end else if (parallel) begin
            cnt_next = `SER_CNT_RST;
            unique case (phase_reg)
                host_port_pkg::IDLE: begin
                    if (acc_read) begin
                        phase_next = host_port_pkg::READ_CYCLE;
                        rreq_next = 1'b1;
                    end else if (acc_write) begin
                        phase_next = host_port_pkg::WRITE_CYCLE;
                    end
                end
                host_port_pkg::READ_CYCLE: begin
                    out_next = READ_DATA;
                    oe_n_next = 8'h00;
                    if (!acc_read) begin
                        phase_next = host_port_pkg::IDLE;
                        oe_n_next = 8'hff;
                    end
                end
                host_port_pkg::WRITE_CYCLE: begin
                    // latch the byte while the strobe is still active
                    if (acc_write) begin
                        wdata_next = d_sync_reg;
                        wflag_next = flag_sync_reg[1];
                    end else begin
                        phase_next = host_port_pkg::IDLE;
                        wvalid_next = 1'b1;
                    end
                end
            endcase
        end else begin
            // serial: write only, bus never driven
            phase_next = host_port_pkg::IDLE;
            if (sclk_rise) begin
                shift_next = {shift_reg[6:0], d_sync_reg[`SER_DATA_BIT]};
                if (cnt_reg == `SER_BITS - 4'h1) begin
                    cnt_next = `SER_CNT_RST;
                    wdata_next = {shift_reg[6:0], d_sync_reg[`SER_DATA_BIT]};
                    wflag_next = flag_sync_reg[1];
                    wvalid_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            phase_reg <= host_port_pkg::IDLE;
            out_reg <= `BYTE_RST;
            oe_n_reg <= 8'hff;
            wdata_reg <= `BYTE_RST;
            wflag_reg <= 1'b0;
            wvalid_reg <= 1'b0;
            rreq_reg <= 1'b0;
            init_reg <= 1'b1;
            shift_reg <= `BYTE_RST;
            cnt_reg <= `SER_CNT_RST;
            sclk_prev_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
            wdata_reg <= wdata_next;
            wflag_reg <= wflag_next;
            wvalid_reg <= wvalid_next;
            rreq_reg <= rreq_next;
            init_reg <= init_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            sclk_prev_reg <= sclk_prev_next;
        end
    end

    // outputs straight from flip-flops
    assign DATA_OUT = out_reg;
    assign DATA_OE_N = oe_n_reg;
    assign WRITE_DATA = wdata_reg;
    assign WRITE_IS_DISPLAY = wflag_reg;
    assign WRITE_VALID = wvalid_reg;
    assign READ_REQ = rreq_reg;
    assign INIT_ACTIVE = init_reg;

endmodule

// ---- host_port_properties.sv ----
`timescale 1ns/10ps
module host_port_properties (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic SELECT_LOW_N,
    input wire logic BUS_STYLE_SELECT,
    input wire logic PARALLEL_SERIAL_SELECT,
    input wire logic READ_STROBE_N,
    input wire logic [7:0] DATA_OE_N,
    input wire logic READ_REQ,
    input wire logic WRITE_VALID
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    a_desel_hiz: assert property (SELECT_LOW_N[*5] |-> &DATA_OE_N)
        else $error("bus driven while deselected");
    a_desel_idle: assert property (
        SELECT_LOW_N[*5] |-> !WRITE_VALID && !READ_REQ)
        else $error("transfer while deselected");
    a_serial_quiet: assert property (
        !PARALLEL_SERIAL_SELECT[*5] |-> &DATA_OE_N && !READ_REQ)
        else $error("serial mode drives bus");
    a_idle_8080: assert property (
        (!BUS_STYLE_SELECT && READ_STROBE_N)[*5] |-> &DATA_OE_N)
        else $error("driven without read strobe");
    a_idle_6800: assert property (
        (BUS_STYLE_SELECT && !READ_STROBE_N)[*5] |-> &DATA_OE_N)
        else $error("driven without enable");
    a_bus_whole: assert property (!DATA_OE_N[0] |-> DATA_OE_N == 8'h00)
        else $error("bus lines driven apart");
    a_write_pulse: assert property (WRITE_VALID |=> !WRITE_VALID)
        else $error("write pulse too long");
    a_read_pulse: assert property (READ_REQ |=> !READ_REQ)
        else $error("read pulse too long");
endmodule
bind lcd_driver_host_interface host_port_properties chk_u (
    .REF_CLK(REF_CLK), .RESET(RESET), .SELECT_LOW_N(SELECT_LOW_N),
    .BUS_STYLE_SELECT(BUS_STYLE_SELECT), .READ_STROBE_N(READ_STROBE_N),
    .PARALLEL_SERIAL_SELECT(PARALLEL_SERIAL_SELECT),
    .DATA_OE_N(DATA_OE_N), .READ_REQ(READ_REQ), .WRITE_VALID(WRITE_VALID));

// ---- host_cpu_model.sv ----
`timescale 1ns/10ps
module host_cpu_model (
    input wire logic clk,
    input wire logic [7:0] din,
    output logic sty,
    output logic flag,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] hbus
);
    // idle 8080 bus at time zero
    initial begin
        {sty, flag, rd_n, wr_n, hbus} = 12'h330;
    end
    // wait n edges, then step off the edge
    task automatic go(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // change bus style with strobes idle for it
    task automatic mode(input logic s);
        sty = s;
        rd_n = !s;
        wr_n = 1'b1;
        go(8);
    endtask
    // one parallel cycle; r high reads
    task automatic par(input logic r, input logic f, input logic [7:0] b,
                       output logic [7:0] got);
        flag = f;
        hbus = r ? ~hbus : b;
        wr_n = sty ? r : 1'b1;
        go(3);
        if (sty) rd_n = 1'b1;
        else if (r) rd_n = 1'b0;
        else wr_n = 1'b0;
        go(8);
        got = din;
        rd_n = !sty;
        wr_n = sty ? r : 1'b1;
        hbus = ~hbus;
        go(8);
    endtask
    // n bits of a serial byte, msb first on rising clock
    task automatic ser(input logic f, input logic [7:0] b, input int n);
        flag = f;
        rd_n = 1'b1;
        wr_n = 1'b1;
        for (int i = 7; i > 7 - n; i--) begin
            hbus[7:6] = {b[i], 1'b0};
            go(4);
            hbus[6] = 1'b1;
            go(4);
        end
        hbus[7:6] = {~hbus[7], 1'b0};
        go(8);
    endtask
endmodule

// ---- lcd_driver_host_interface_tb_top.sv ----
`timescale 1ns/10ps
module lcd_driver_host_interface_tb_top;
    logic clk = 0, rst = 1, init_n = 1, sel_n = 0, sel = 1, ps = 1;
    logic [7:0] rdata = 8'h3c, dout, oe_n, wdata, hbus, din, got;
    logic sty, flag, rd_n, wr_n, rreq, wv, disp, iact;
    int error_cnt = 0, checks_done = 0, cyc = 0, nw = 0, nr = 0;
    always #10 clk = ~clk;
    // bus level seen by both sides
    assign din = dout & ~oe_n | hbus & oe_n;
    host_cpu_model cpu_u (.clk(clk), .din(din), .sty(sty), .flag(flag),
        .rd_n(rd_n), .wr_n(wr_n), .hbus(hbus));
    lcd_driver_host_interface dut_u (.REF_CLK(clk), .RESET(rst),
        .INIT_REQUEST_N(init_n), .SELECT_LOW_N(sel_n), .SELECT_HIGH(sel),
        .CMD_DATA_FLAG(flag), .BUS_STYLE_SELECT(sty),
        .PARALLEL_SERIAL_SELECT(ps), .READ_STROBE_N(rd_n),
        .STORE_STROBE_N(wr_n), .DATA_IN(din), .DATA_OUT(dout),
        .DATA_OE_N(oe_n), .READ_DATA(rdata), .READ_REQ(rreq),
        .WRITE_DATA(wdata), .WRITE_IS_DISPLAY(disp), .WRITE_VALID(wv),
        .INIT_ACTIVE(iact));
    // pulse counters and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wv === 1'b1) nw <= nw + 1;
        if (rreq === 1'b1) nr <= nr + 1;
        if (cyc == 9000) begin
            error_cnt++;
            wrap_up;
        end
    end
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        checks_done++;
        if (act !== exp) begin
            error_cnt++;
            $display("ERROR %0t act %h exp %h", $time, act, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // write then read in each style with each flag value
    task automatic t_par;
        int w;
        for (int s = 0; s < 4; s++) begin
            cpu_u.mode(s[1]);
            w = nw + nr;
            cpu_u.par(1'b0, s[0], 8'h96 + 8'(s), got);
            chk(wdata, 8'h96 + 8'(s));
            chk({7'h0, disp}, {7'h0, s[0]});
            rdata = ~wdata;
            cpu_u.par(1'b1, s[0], 8'h00, got);
            chk(got, rdata);
            chk(8'(nw + nr - w), 8'h02);
        end
    endtask
    // nothing taken or driven while deselected
    task automatic t_desel;
        int w;
        w = nw + nr;
        sel_n = 1'b1;
        cpu_u.par(1'b0, 1'b1, 8'h11, got);
        {sel_n, sel} = 2'b00;
        cpu_u.par(1'b1, 1'b1, 8'h00, got);
        // model flips its own level again after sampling
        chk(got, ~hbus);
        chk(8'(nw + nr - w), 8'h00);
        sel = 1'b1;
        init_n = 1'b0;
        cpu_u.go(6);
        chk({7'h0, iact}, 8'h01);
        cpu_u.par(1'b0, 1'b0, 8'h77, got);
        chk(8'(nw + nr - w), 8'h00);
        init_n = 1'b1;
    endtask
    // partial serial byte dropped by deselect, then a whole byte
    task automatic t_ser;
        int w;
        cpu_u.mode(1'b0);
        ps = 1'b0;
        w = nw;
        cpu_u.ser(1'b1, 8'ha5, 3);
        sel_n = 1'b1;
        cpu_u.go(6);
        sel_n = 1'b0;
        cpu_u.ser(1'b1, 8'h6b, 8);
        chk(wdata, 8'h6b);
        chk({7'h0, disp}, 8'h01);
        chk(8'(nw - w), 8'h01);
        chk(oe_n, 8'hff);
    endtask
    initial begin
        cpu_u.go(3);
        rst = 1'b0;
        cpu_u.go(4);
        t_par;
        t_desel;
        t_ser;
        wrap_up;
    end
endmodule
